// ### rtl/ssoc_link_if.sv
/*
 * Link between one sensor (documented device) and the outside party:
 * safety outputs, chain feed, contactor feedback, diagnostic reset.
 * Assumes both ends share clk; no tri-state wires are carried.
 */
`timescale 1ns/1ps

interface ssoc_link_if;
    logic guard_out_a;
    logic guard_out_b;
    logic chain_in_a;
    logic chain_in_b;
    logic contactor_fb;
    logic diag_rst_req;
    logic [ssoc_pkg::DIAG_ADDR_W-1:0] diag_rst_addr;

    modport sensor (
        output guard_out_a,
        output guard_out_b,
        input chain_in_a,
        input chain_in_b,
        input contactor_fb,
        input diag_rst_req,
        input diag_rst_addr
    );

    modport monitor (
        input guard_out_a,
        input guard_out_b,
        output chain_in_a,
        output chain_in_b,
        output contactor_fb,
        output diag_rst_req,
        output diag_rst_addr
    );
endinterface

// ### rtl/ssoc_monitor.sv
/*
 * Outside party: feeds the chain inputs, loops back contactor feedback,
 * forwards diagnostic reset commands, and evaluates the two safety
 * channels with test-impulse blanking and a discrepancy timer.
 * Assumes user inputs are synchronous to clk.
 */
`timescale 1ns/1ps

module ssoc_monitor #(
    parameter int unsigned BLANK_CYC = ssoc_pkg::BLANK_CYC,
    parameter int unsigned DISC_CYC = ssoc_pkg::DISC_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    ssoc_link_if.monitor lk,
    input wire logic feed_chain,
    input wire logic contactor_nc_closed,
    input wire logic diag_reset_req,
    input wire logic [ssoc_pkg::DIAG_ADDR_W-1:0] diag_reset_addr,
    output logic ch_a_ok,
    output logic ch_b_ok,
    output logic safe_release,
    output logic disc_fault
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic feed;
        logic fb;
        logic rst_req;
        logic [ssoc_pkg::DIAG_ADDR_W-1:0] rst_addr;
        logic [ssoc_pkg::BLANK_CNT_W-1:0] low_a;
        logic [ssoc_pkg::BLANK_CNT_W-1:0] low_b;
        logic ok_a;
        logic ok_b;
        logic [ssoc_pkg::DISC_CNT_W-1:0] disc_cnt;
        logic fault;
    } ssoc_monitor_s;

    ssoc_monitor_s cur_ff;
    ssoc_monitor_s nxt_cur;

    localparam logic [ssoc_pkg::BLANK_CNT_W-1:0] BLANK_LAST =
        ssoc_pkg::BLANK_CNT_W'(BLANK_CYC - 1);
    localparam logic [ssoc_pkg::DISC_CNT_W-1:0] DISC_LAST =
        ssoc_pkg::DISC_CNT_W'(DISC_CYC - 1);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Low-time counter: held at the limit, cleared when the input is high
    function automatic logic [ssoc_pkg::BLANK_CNT_W-1:0] low_step(
        input logic level, input logic [ssoc_pkg::BLANK_CNT_W-1:0] cnt);
        if (level) begin
            low_step = '0;
        end else if (cnt >= BLANK_LAST) begin
            low_step = cnt;
        end else begin
            low_step = cnt + 1'b1;
        end
    endfunction

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.feed = feed_chain;
        nxt_cur.fb = contactor_nc_closed;
        nxt_cur.rst_req = diag_reset_req;
        nxt_cur.rst_addr = diag_reset_addr;

        // Each channel judged on its own; no cross-short pattern applied
        nxt_cur.low_a = low_step(lk.guard_out_a, cur_ff.low_a);
        nxt_cur.low_b = low_step(lk.guard_out_b, cur_ff.low_b);
        // A channel is lost only once low outlasts the blanking window
        nxt_cur.ok_a = lk.guard_out_a || (cur_ff.ok_a && cur_ff.low_a < BLANK_LAST);
        nxt_cur.ok_b = lk.guard_out_b || (cur_ff.ok_b && cur_ff.low_b < BLANK_LAST);

        // Discrepancy tolerated up to the window, then latched
        if (cur_ff.ok_a != cur_ff.ok_b) begin
            if (cur_ff.disc_cnt >= DISC_LAST) begin
                nxt_cur.fault = 1'b1;
            end else begin
                nxt_cur.disc_cnt = cur_ff.disc_cnt + 1'b1;
            end
        end else begin
            nxt_cur.disc_cnt = '0;
            // Cleared only once both channels have gone off together
            if (!cur_ff.ok_a && !cur_ff.ok_b) begin
                nxt_cur.fault = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign lk.chain_in_a = cur_ff.feed;
    assign lk.chain_in_b = cur_ff.feed;
    assign lk.contactor_fb = cur_ff.fb;
    assign lk.diag_rst_req = cur_ff.rst_req;
    assign lk.diag_rst_addr = cur_ff.rst_addr;
    assign ch_a_ok = cur_ff.ok_a;
    assign ch_b_ok = cur_ff.ok_b;
    assign safe_release = cur_ff.ok_a && cur_ff.ok_b && !cur_ff.fault;
    assign disc_fault = cur_ff.fault;

endmodule

// ### rtl/ssoc_pkg.sv
/*
 * Shared constants and types for the safety output chain control ends:
 * clock rate, self-test and monitor timing, diagnostic addressing, modes.
 * Assumes a single 10 MHz clock common to both ends.
 */
package ssoc_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned CLK_PER_MHZ = CLK_HZ / 1_000_000;

    // Self-test switch-off: typical interval, longest pulse
    localparam int unsigned TEST_INTERVAL_MS = 1000;
    localparam int unsigned TEST_INTERVAL_CYC = TEST_INTERVAL_MS * (CLK_HZ / 1000);
    localparam int unsigned TEST_PULSE_NS = 300_000;
    // Longest time: rounds down
    localparam int unsigned TEST_PULSE_CYC = (TEST_PULSE_NS * CLK_PER_MHZ) / 1000;

    // Monitor side: test impulse blanking and channel discrepancy
    localparam int unsigned BLANK_US = 1000;
    localparam int unsigned BLANK_CYC = BLANK_US * CLK_PER_MHZ;
    localparam int unsigned DISC_MS = 100;
    localparam int unsigned DISC_CYC = DISC_MS * (CLK_HZ / 1000);

    // Counter widths sized for the figures above
    localparam int unsigned TEST_CNT_W = 24;
    localparam int unsigned PULSE_CNT_W = 12;
    localparam int unsigned BLANK_CNT_W = 14;
    localparam int unsigned DISC_CNT_W = 20;

    // ------------------------------------------------------------
    // Serial diagnostic addressing
    // ------------------------------------------------------------
    localparam int unsigned DIAG_ADDR_W = 5;
    localparam int unsigned DIAG_NODES_MAX = 31;
    localparam logic [DIAG_ADDR_W-1:0] DIAG_BCAST_ADDR = 5'h00;
    localparam logic [DIAG_ADDR_W-1:0] DIAG_ADDR_RST = 5'h01;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SSOC_MODE_MONITORED = 2'h0,
        SSOC_MODE_AUTO_START = 2'h1,
        SSOC_MODE_RELEASE_START = 2'h2
    } ssoc_mode_e;

    typedef enum logic [1:0] {
        SSOC_ST_OFF = 2'h0,
        SSOC_ST_ARMED = 2'h1,
        SSOC_ST_ON = 2'h2
    } ssoc_state_e;

endpackage

// ### rtl/ssoc_sensor.sv
/*
 * Sensor end: dual-channel safety outputs with periodic self-test
 * switch-offs, chain input gating, direct contactor drive variants and
 * emergency-stop error latch with button or diagnostic acknowledgement.
 * Assumes all user inputs are synchronous to clk and debounced.
 */

// Overview of operation
// - Periodically pulse each output off for self-test
// - Pulses every 1000 ms, at most 0.3 ms
// - Monitor blanks roughly 1 ms test impulses
// - Monitor allows at least 100 ms discrepancy
// - Monitor disables its own cross-short supervision
// - Monitor has two independent source-type channels
// - Actuator leaving zone drops both outputs immediately
// - Chain adds only input reaction time
// - Chainable, up to 31 diagnostic nodes
// - Outside feeds last inputs, monitors first outputs
// - Gateway wired to first sensor diagnostic input
// - Auto start: enable at once, check feedback
// - Feedback-loop button switches on without edge
// - Release start: enable on button falling edge
// - Emergency-stop error cleared by acknowledge button
// - Diagnostic reset command clears emergency-stop error
`timescale 1ns/1ps

module ssoc_sensor #(
    parameter int unsigned TEST_INTERVAL_CYC = ssoc_pkg::TEST_INTERVAL_CYC,
    parameter logic [ssoc_pkg::DIAG_ADDR_W-1:0] NODE_ADDR = ssoc_pkg::DIAG_ADDR_RST
) (
    input wire logic clk,
    input wire logic rstn,
    ssoc_link_if.sensor lk,
    input wire logic actuator_present,
    input wire ssoc_pkg::ssoc_mode_e mode,
    input wire logic estop_variant,
    input wire logic serial_diag_option,
    input wire logic reset_button,
    input wire logic ack_button,
    output logic outputs_on,
    output logic error_latched,
    output logic test_active
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        ssoc_pkg::ssoc_state_e st;
        logic [ssoc_pkg::TEST_CNT_W-1:0] test_cnt;
        logic [ssoc_pkg::PULSE_CNT_W-1:0] pulse_cnt;
        logic pulsing;
        logic test_chan_b;
        logic btn_prev;
        logic err;
        logic out_a;
        logic out_b;
    } ssoc_sensor_s;

    ssoc_sensor_s cur_ff;
    ssoc_sensor_s nxt_cur;

    localparam logic [ssoc_pkg::TEST_CNT_W-1:0] TEST_LAST =
        ssoc_pkg::TEST_CNT_W'(TEST_INTERVAL_CYC - 1);
    localparam logic [ssoc_pkg::PULSE_CNT_W-1:0] PULSE_LAST =
        ssoc_pkg::PULSE_CNT_W'(ssoc_pkg::TEST_PULSE_CYC - 1);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Diagnostic reset aimed at this node or broadcast
    function automatic logic diag_hit(input logic req,
                                      input logic [ssoc_pkg::DIAG_ADDR_W-1:0] addr);
        diag_hit = req && (addr == NODE_ADDR || addr == ssoc_pkg::DIAG_BCAST_ADDR);
    endfunction

    logic chain_ok;
    logic chain_split;
    logic safe_cond;
    logic fb_closed;
    logic direct_mode;
    logic err_clear;
    logic err_set;

    // ------------------------------------------------------------
    // Combinational conditions
    // ------------------------------------------------------------
    // Chain inputs enter the state directly: one register stage per unit
    assign chain_ok = lk.chain_in_a && lk.chain_in_b;
    // One channel up with the other down means a tripped stop in the chain
    assign chain_split = lk.chain_in_a ^ lk.chain_in_b;
    assign fb_closed = lk.contactor_fb;
    assign direct_mode = (mode != ssoc_pkg::SSOC_MODE_MONITORED);
    assign err_set = estop_variant && chain_split;
    // Acknowledge route depends on whether the diagnostic channel exists
    assign err_clear = serial_diag_option
        ? diag_hit(lk.diag_rst_req, lk.diag_rst_addr)
        : ack_button;
    assign safe_cond = actuator_present && chain_ok && !cur_ff.err;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.btn_prev = reset_button;

        // Error latch; a fresh fault wins over a same-cycle acknowledge
        if (err_set) begin
            nxt_cur.err = 1'b1;
        end else if (err_clear) begin
            nxt_cur.err = 1'b0;
        end

        // Self-test timebase runs free so the pulse cadence is fixed
        if (cur_ff.test_cnt >= TEST_LAST) begin
            nxt_cur.test_cnt = '0;
            nxt_cur.pulsing = 1'b1;
            nxt_cur.pulse_cnt = '0;
        end else begin
            nxt_cur.test_cnt = cur_ff.test_cnt + 1'b1;
        end
        if (cur_ff.pulsing) begin
            if (cur_ff.pulse_cnt >= PULSE_LAST) begin
                nxt_cur.pulsing = 1'b0;
                // Alternate channels so each one is proven off in turn
                nxt_cur.test_chan_b = !cur_ff.test_chan_b;
            end else begin
                nxt_cur.pulse_cnt = cur_ff.pulse_cnt + 1'b1;
            end
        end

        // Enable sequencing
        case (cur_ff.st)
            ssoc_pkg::SSOC_ST_OFF: begin
                if (safe_cond) begin
                    case (mode)
                        ssoc_pkg::SSOC_MODE_AUTO_START: begin
                            // Level only: a button in the loop acts at once
                            if (fb_closed) begin
                                nxt_cur.st = ssoc_pkg::SSOC_ST_ON;
                            end
                        end
                        ssoc_pkg::SSOC_MODE_RELEASE_START: begin
                            if (fb_closed) begin
                                nxt_cur.st = ssoc_pkg::SSOC_ST_ARMED;
                            end
                        end
                        default: begin
                            nxt_cur.st = ssoc_pkg::SSOC_ST_ON;
                        end
                    endcase
                end
            end
            ssoc_pkg::SSOC_ST_ARMED: begin
                if (!safe_cond || !fb_closed) begin
                    nxt_cur.st = ssoc_pkg::SSOC_ST_OFF;
                end else if (cur_ff.btn_prev && !reset_button) begin
                    // Only the release edge starts, a held button never does
                    nxt_cur.st = ssoc_pkg::SSOC_ST_ON;
                end
            end
            ssoc_pkg::SSOC_ST_ON: begin
                // Contactor feedback opens while energised, so it is not checked here
                if (!safe_cond) begin
                    nxt_cur.st = ssoc_pkg::SSOC_ST_OFF;
                end
            end
            default: begin
                nxt_cur.st = ssoc_pkg::SSOC_ST_OFF;
            end
        endcase

        // Outputs follow the next state so a drop-out costs no extra cycle
        nxt_cur.out_a = (nxt_cur.st == ssoc_pkg::SSOC_ST_ON)
            && !(nxt_cur.pulsing && !nxt_cur.test_chan_b);
        nxt_cur.out_b = (nxt_cur.st == ssoc_pkg::SSOC_ST_ON)
            && !(nxt_cur.pulsing && nxt_cur.test_chan_b);
        if (direct_mode && !fb_closed && cur_ff.st != ssoc_pkg::SSOC_ST_ON) begin
            nxt_cur.out_a = 1'b0;
            nxt_cur.out_b = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cur_ff <= '{st: ssoc_pkg::SSOC_ST_OFF, default: '0};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Source-type outputs: high means channel active
    assign lk.guard_out_a = cur_ff.out_a;
    assign lk.guard_out_b = cur_ff.out_b;
    assign outputs_on = (cur_ff.st == ssoc_pkg::SSOC_ST_ON);
    assign error_latched = cur_ff.err;
    assign test_active = cur_ff.pulsing;

endmodule

// ### test/safety_output_chain_control_tb_top.sv
/*
 * Testbench: sensor and monitor joined by a link, plus a second sensor
 * whose far side the bench drives to break the chain on purpose.
 * Assumes the design files are compiled first.
 */
`timescale 1ns/1ps

module safety_output_chain_control_tb_top;
    localparam int unsigned INTERVAL = 5000;
    localparam int PULSE = ssoc_pkg::TEST_PULSE_CYC;

    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic act = 1'b0;
    ssoc_pkg::ssoc_mode_e mode = ssoc_pkg::SSOC_MODE_MONITORED;
    logic estop = 1'b0;
    logic sdo = 1'b0;
    logic btn = 1'b0;
    logic ack = 1'b0;
    logic feed = 1'b0;
    logic nc = 1'b0;
    logic dreq = 1'b0;
    logic [4:0] daddr = 5'h00;
    logic on0, on1, err0, err1, rel, tact;
    int err_total = 0;
    int tests_run = 0;
    int m_st[2], m_err[2], m_prev[2];
    int m_feed, m_nc, m_dq, m_da;

    ssoc_link_if lk();
    ssoc_link_if lk_bad();

    always #50 clk = ~clk;

    // ------------------------------------------------------------
    // Design ends and checker
    // ------------------------------------------------------------
    ssoc_sensor #(.TEST_INTERVAL_CYC(INTERVAL)) ssoc_sensor_inst (.clk(clk), .rstn(rstn),
        .lk(lk.sensor), .actuator_present(act), .mode(mode), .estop_variant(estop),
        .serial_diag_option(sdo), .reset_button(btn), .ack_button(ack), .outputs_on(on0),
        .error_latched(err0), .test_active(tact));
    ssoc_sensor #(.TEST_INTERVAL_CYC(INTERVAL)) ssoc_sensor_inst2 (.clk(clk), .rstn(rstn),
        .lk(lk_bad.sensor), .actuator_present(act), .mode(mode), .estop_variant(estop),
        .serial_diag_option(sdo), .reset_button(btn), .ack_button(ack), .outputs_on(on1),
        .error_latched(err1), .test_active());
    // Blanking must outlast the fixed 3000-cycle switch-off
    ssoc_monitor #(.BLANK_CYC(4000), .DISC_CYC(100)) ssoc_monitor_inst (.clk(clk),
        .rstn(rstn), .lk(lk.monitor), .feed_chain(feed), .contactor_nc_closed(nc),
        .diag_reset_req(dreq), .diag_reset_addr(daddr), .ch_a_ok(), .ch_b_ok(),
        .safe_release(rel), .disc_fault());
    ssoc_link_chk #(.TEST_INTERVAL_CYC(INTERVAL)) ssoc_link_chk_inst (.clk(clk), .rstn(rstn),
        .guard_out_a(lk.guard_out_a), .guard_out_b(lk.guard_out_b),
        .chain_in_a(lk.chain_in_a), .chain_in_b(lk.chain_in_b),
        .contactor_fb(lk.contactor_fb), .diag_rst_req(lk.diag_rst_req),
        .diag_rst_addr(lk.diag_rst_addr));

    // ------------------------------------------------------------
    // Reference model: monitor delays one cycle, sensor states 0/1/2
    // ------------------------------------------------------------
    always @(posedge clk or negedge rstn) begin
        int ca, cb, fb, dq, da, nst, clr;
        if (!rstn) begin
            m_st = '{0, 0};
            m_err = '{0, 0};
            m_prev = '{0, 0};
            m_feed = 0;
            m_nc = 0;
            m_dq = 0;
            m_da = 0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                ca = i ? lk_bad.chain_in_a : m_feed;
                cb = i ? lk_bad.chain_in_b : m_feed;
                fb = i ? lk_bad.contactor_fb : m_nc;
                dq = i ? lk_bad.diag_rst_req : m_dq;
                da = i ? lk_bad.diag_rst_addr : m_da;
                clr = sdo ? (dq && (da == 0 || da == 1)) : ack;
                // Armed waits for the release edge whatever the mode is now
                if (!(act && ca && cb && !m_err[i])) nst = 0;
                else if (m_st[i] == 2) nst = 2;
                else if (m_st[i] == 1) nst = !fb ? 0 : ((m_prev[i] && !btn) ? 2 : 1);
                else if (mode == ssoc_pkg::SSOC_MODE_MONITORED) nst = 2;
                else if (mode == ssoc_pkg::SSOC_MODE_AUTO_START) nst = fb ? 2 : 0;
                else nst = fb ? 1 : 0;
                // Set wins over a clear in the same cycle
                m_err[i] = (estop && ca != cb) ? 1 : (clr ? 0 : m_err[i]);
                m_st[i] = nst;
                m_prev[i] = btn;
            end
            m_feed = feed;
            m_nc = nc;
            m_dq = dreq;
            m_da = daddr;
        end
    end

    task automatic chk(input logic seen, input logic exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t value %b, expected %b", $time, seen, exp);
        end
    endtask

    // Compare every cycle, away from the launching edge
    always @(negedge clk) begin
        chk(on0, logic'(m_st[0] == 2));
        chk(on1, logic'(m_st[1] == 2));
        chk(err0, logic'(m_err[0] != 0));
        chk(err1, logic'(m_err[1] != 0));
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wrap_up();
        if (err_total == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Watchdog: run needs about 16000 cycles
    initial begin
        #4_000_000;
        err_total++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial begin
        int low, drop, n, tcnt;
        logic [4:0] addrs[$];
        n = $urandom(32'h88c7);
        addrs = '{5'h03, 5'h00, 5'h01};
        lk_bad.chain_in_a = 1'b1;
        lk_bad.chain_in_b = 1'b1;
        lk_bad.contactor_fb = 1'b1;
        lk_bad.diag_rst_req = 1'b0;
        lk_bad.diag_rst_addr = 5'h00;
        tick(2);
        rstn = 1'b1;
        // Release start: held button never starts, release does
        feed = 1'b1;
        nc = 1'b1;
        act = 1'b1;
        mode = ssoc_pkg::SSOC_MODE_RELEASE_START;
        btn = 1'b1;
        tick(6);
        btn = 1'b0;
        tick(4);
        // Long hold: one switch-off per channel, monitor keeps release
        mode = ssoc_pkg::SSOC_MODE_MONITORED;
        tick(10);
        low = 0;
        drop = 0;
        tcnt = 0;
        // Window starts at the first switch-off so it holds two whole ones
        do @(negedge clk); while (lk.guard_out_a);
        repeat (2 * INTERVAL) begin
            low += int'(!lk.guard_out_a) + int'(!lk.guard_out_b);
            drop += int'(!rel);
            tcnt += int'(tact);
            @(negedge clk);
        end
        tick(1);
        chk(logic'(low == 2 * PULSE), 1'b1);
        chk(logic'(tcnt == 2 * PULSE), 1'b1);
        chk(logic'(drop == 0), 1'b1);
        // Random starts, feedback, button and feed losses
        repeat (40) begin
            act = 1'b0;
            mode = ssoc_pkg::ssoc_mode_e'($urandom_range(2, 0));
            nc = 1'(($urandom % 4) != 0);
            lk_bad.contactor_fb = nc;
            tick(2);
            act = 1'b1;
            feed = 1'(($urandom % 5) != 0);
            dreq = 1'($urandom);
            daddr = 5'($urandom);
            tick(1 + $urandom % 20);
            btn = 1'b1;
            dreq = 1'b0;
            tick(1 + $urandom % 3);
            btn = 1'b0;
            tick(2 + $urandom % 30);
        end
        // Broken chain on the second sensor: acknowledge by button
        mode = ssoc_pkg::SSOC_MODE_MONITORED;
        estop = 1'b1;
        feed = 1'b1;
        tick(3);
        lk_bad.chain_in_a = 1'b0;
        tick(1);
        lk_bad.chain_in_a = 1'b1;
        tick(3);
        lk_bad.chain_in_b = 1'b0;
        ack = 1'b1;
        tick(1);
        lk_bad.chain_in_b = 1'b1;
        tick(2);
        ack = 1'b0;
        tick(3);
        // Clear over the diagnostic path: foreign, broadcast, own node
        sdo = 1'b1;
        foreach (addrs[k]) begin
            lk_bad.chain_in_a = 1'b0;
            tick(1);
            lk_bad.chain_in_a = 1'b1;
            lk_bad.diag_rst_req = 1'b1;
            lk_bad.diag_rst_addr = addrs[k];
            tick(1);
            lk_bad.diag_rst_req = 1'b0;
            tick(3);
        end
        // Reset in mid-run while on
        rstn = 1'b0;
        tick(2);
        rstn = 1'b1;
        tick(8);
        wrap_up();
    end
endmodule

// ### test/ssoc_link_monitor.sv
/*
 * Link checker: self-test pulse shape and spacing, chain feed pairing,
 * switch-off on feed loss, channel A output and chain feed quiet after reset.
 * Assumes it is instantiated beside the link that joins the two ends.
 */
`timescale 1ns/1ps

module ssoc_link_chk #(
    parameter int unsigned TEST_INTERVAL_CYC = ssoc_pkg::TEST_INTERVAL_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic guard_out_a,
    input wire logic guard_out_b,
    input wire logic chain_in_a,
    input wire logic chain_in_b,
    input wire logic contactor_fb,
    input wire logic diag_rst_req,
    input wire logic [ssoc_pkg::DIAG_ADDR_W-1:0] diag_rst_addr
);
    localparam int PULSE = ssoc_pkg::TEST_PULSE_CYC;
    // Counter may start a few cycles late after reset release
    localparam int GAP_MIN = TEST_INTERVAL_CYC - 2;

    logic [15:0] mis_ff;
    logic [31:0] gap_ff;
    logic both_q_ff;
    logic clean_ff;
    logic mis;
    logic start;

    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    assign mis = guard_out_a != guard_out_b;
    assign start = mis && (mis_ff == 16'h0000);

    // Only pulses that begin from both channels high count as whole
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mis_ff <= 16'h0000;
            gap_ff <= 32'h0;
            both_q_ff <= 1'b0;
            clean_ff <= 1'b0;
        end else begin
            mis_ff <= mis ? mis_ff + 16'h0001 : 16'h0000;
            gap_ff <= (start && both_q_ff) ? 32'h1 : gap_ff + 32'h1;
            both_q_ff <= guard_out_a && guard_out_b;
            clean_ff <= start ? both_q_ff : clean_ff;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence s_pulse_start;
        start && both_q_ff;
    endsequence

    sequence s_pulse_end;
        $past(mis) && guard_out_a && guard_out_b && clean_ff;
    endsequence

    AST_PULSE_MAX: assert property (mis_ff <= PULSE)
        else $error("channel switch-off longer than allowed");
    AST_PULSE_LEN: assert property (s_pulse_end |-> $past(mis_ff) == PULSE - 1)
        else $error("self-test switch-off of wrong length");
    AST_PULSE_GAP: assert property (s_pulse_start |-> gap_ff >= GAP_MIN)
        else $error("self-test switch-offs too close together");
    AST_MIS_FEED: assert property (mis |-> $past(chain_in_a && chain_in_b))
        else $error("channels differ without chain feed");
    AST_DROP: assert property ($fell(chain_in_a) |=> !guard_out_a && !guard_out_b)
        else $error("outputs kept on after feed loss");
    AST_RISE_FEED: assert property ($rose(guard_out_a) |-> $past(chain_in_a && chain_in_b))
        else $error("output rose without chain feed");
    AST_CHAIN_PAIR: assert property (chain_in_a == chain_in_b)
        else $error("chain feed lines disagree");
    AST_RESET_OFF: assert property (!$past(rstn) |-> !guard_out_a && !chain_in_a)
        else $error("link active right after reset");
endmodule
